// >>> src/pursq_regs.vh
// Purpose: Constants for the power-up reset sequencer.
// Assumes: 50 MHz core clock; internal RC oscillator and oscillator input arrive as pin levels.
// Notes: The delay is given in ms and its RC cycle count derived from it; the start-up count is given in cycles.
`ifndef PURSQ_REGS_VH
`define PURSQ_REGS_VH
`define PURSQ_DELAY_MS        72
`define PURSQ_RC_HZ           32000
`define PURSQ_OST_CYCLES      1024
`define PURSQ_MODE_RC         2'h0
`define PURSQ_MODE_LP         2'h1
`define PURSQ_MODE_XT         2'h2
`define PURSQ_MODE_HS         2'h3
`define PURSQ_ADR_CTRL        2'h0
`define PURSQ_ADR_STAT        2'h1
`define PURSQ_BIT_POR         0
`define PURSQ_BIT_BOR         1
`define PURSQ_BIT_INRST       2
`define PURSQ_ST_SHIFT        3
`define PURSQ_ZERO32          32'h0000_0000
`define PURSQ_ONE32           32'h0000_0001
`define PURSQ_SYNC_IN         0
`define PURSQ_SYNC_OUT        1
`define PURSQ_ADR_HI          3
`define PURSQ_ADR_LO          2
`define PURSQ_ST_WIDTH        3
`define PURSQ_LANE0           0
`define PURSQ_BIT_SLEEP       0
`endif

// >>> src/pursq_sequencer.v
// Purpose: Power-up reset sequencer with power-up delay, oscillator start-up count and flags.
// Assumes: Supply monitors, RC oscillator and oscillator input are asynchronous pin levels.
// Notes: Registers are reached over classic Wishbone; ack comes one cycle after the strobe.
//
// Added by the designer: the Wishbone slave port and the address map.
`include "pursq_regs.vh"
module pursq_sequencer #(
	parameter DELAY_RC_CYCLES = (`PURSQ_DELAY_MS * `PURSQ_RC_HZ) / 1000
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        por_good_i,
	input  wire        brownout_low_i,
	input  wire        ext_reset_n_i,
	input  wire        wake_i,
	input  wire        rc_osc_i,
	input  wire        osc_in_i,
	input  wire        power_up_timer_disable_bit_i,
	input  wire        brownout_enable_bit_i,
	input  wire [1:0]  osc_mode_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [3:0]  adr_i,
	input  wire [31:0] dat_i,
	input  wire [3:0]  sel_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output wire        core_reset_o
);
	// Sequencer states, binary coded; the code is also readable in the status word.
	localparam [2:0] ST_POR   = 3'h0;
	localparam [2:0] ST_BOR   = 3'h1;
	localparam [2:0] ST_DELAY = 3'h2;
	localparam [2:0] ST_OST   = 3'h3;
	localparam [2:0] ST_RUN   = 3'h4;
	localparam [2:0] ST_SLEEP = 3'h5;

	// Terminal counts, sized to the counter so the compares never widen or truncate.
	localparam [31:0] DELAY_LAST = DELAY_RC_CYCLES - 1;
	localparam [31:0] OST_LAST   = `PURSQ_OST_CYCLES - 1;

	// Power-on detect comes from an analog monitor; only the second flop is read.
	reg [1:0] por_sync_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			por_sync_q <= 2'h0;
		end else begin
			por_sync_q <= {por_sync_q[`PURSQ_SYNC_IN], por_good_i};
		end
	end

	// Brown-out level; a short glitch may be missed, which the monitor must filter.
	reg [1:0] bo_sync_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			bo_sync_q <= 2'h0;
		end else begin
			bo_sync_q <= {bo_sync_q[`PURSQ_SYNC_IN], brownout_low_i};
		end
	end

	// External reset pin; clearing to low keeps the core held right after reset.
	reg [1:0] ext_sync_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_sync_q <= 2'h0;
		end else begin
			ext_sync_q <= {ext_sync_q[`PURSQ_SYNC_IN], ext_reset_n_i};
		end
	end

	// Wake-up request from sleep.
	reg [1:0] wake_sync_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			wake_sync_q <= 2'h0;
		end else begin
			wake_sync_q <= {wake_sync_q[`PURSQ_SYNC_IN], wake_i};
		end
	end

	// Internal RC oscillator; it must run well below half the core clock.
	reg [1:0] rc_sync_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			rc_sync_q <= 2'h0;
		end else begin
			rc_sync_q <= {rc_sync_q[`PURSQ_SYNC_IN], rc_osc_i};
		end
	end

	// Oscillator input; same limit on its frequency as the RC input.
	reg [1:0] osc_sync_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_sync_q <= 2'h0;
		end else begin
			osc_sync_q <= {osc_sync_q[`PURSQ_SYNC_IN], osc_in_i};
		end
	end

	// Previous oscillator levels. They reset low, the idle level of both inputs,
	// so no false edge is counted just after reset.
	reg rc_prev_q;
	reg osc_prev_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			rc_prev_q  <= 1'b0;
			osc_prev_q <= 1'b0;
		end else begin
			rc_prev_q  <= rc_sync_q[`PURSQ_SYNC_OUT];
			osc_prev_q <= osc_sync_q[`PURSQ_SYNC_OUT];
		end
	end

	// Settled copies of the pins; the brown-out level only counts while enabled.
	wire por_good = por_sync_q[`PURSQ_SYNC_OUT];
	wire bo_low   = bo_sync_q[`PURSQ_SYNC_OUT] & brownout_enable_bit_i;
	wire ext_n    = ext_sync_q[`PURSQ_SYNC_OUT];
	wire wake     = wake_sync_q[`PURSQ_SYNC_OUT];

	// One-cycle strobes on the rising edges of the two oscillators.
	wire rc_rise  = rc_sync_q[`PURSQ_SYNC_OUT] & ~rc_prev_q;
	wire osc_rise = osc_sync_q[`PURSQ_SYNC_OUT] & ~osc_prev_q;

	// Crystal modes need the start-up count, except after a brown-out with the timer disabled; RC mode skips it.
	function crystal;
		input [1:0] m;
		begin
			crystal = (m != `PURSQ_MODE_RC);
		end
	endfunction

	// Word address decode; byte offsets within a word are ignored.
	function reg_hit;
		input [3:0] a;
		input [1:0] code;
		begin
			reg_hit = (a[`PURSQ_ADR_HI:`PURSQ_ADR_LO] == code);
		end
	endfunction

	// Status word: flags at the bottom, state code above the core reset bit.
	function [31:0] status_word;
		input [2:0] st;
		input       inrst;
		input       bo_flag;
		input       po_flag;
		begin
			status_word = `PURSQ_ZERO32;
			status_word[`PURSQ_ST_SHIFT +: `PURSQ_ST_WIDTH] = st;
			status_word[`PURSQ_BIT_INRST] = inrst;
			status_word[`PURSQ_BIT_BOR] = bo_flag;
			status_word[`PURSQ_BIT_POR] = po_flag;
		end
	endfunction

	// Sequencer state and the one counter shared by both timers.
	reg  [2:0]  st_q;
	reg  [31:0] cnt_q;
	reg         por_flag_q;
	reg         bor_flag_q;
	reg         sleep_req_q;

	// The counter starts at zero, so the last count is one short of the total.
	wire        delay_done = (cnt_q >= DELAY_LAST);
	wire        ost_done   = (cnt_q >= OST_LAST);

	// Main sequencer. Supply loss wins over everything, then an enabled brown-out;
	// the delay therefore only ever starts from those two events, never from the pin.
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q  <= ST_POR;
			cnt_q <= `PURSQ_ZERO32;
		end else if (!por_good) begin
			// Supply not yet adequate: park in power-on and keep the timer clear.
			st_q  <= ST_POR;
			cnt_q <= `PURSQ_ZERO32;
		end else if (bo_low) begin
			// A sag during the delay throws the sequence back; it restarts on recovery.
			st_q  <= ST_BOR;
			cnt_q <= `PURSQ_ZERO32;
		end else begin
			case (st_q)
				ST_POR, ST_BOR: begin
					cnt_q <= `PURSQ_ZERO32;
					if (!power_up_timer_disable_bit_i) begin
						st_q <= ST_DELAY;
					end else if (crystal(osc_mode_i) && (st_q == ST_POR)) begin
						st_q <= ST_OST;
					end else begin
						st_q <= ST_RUN;
					end
				end
				ST_DELAY: begin
					// Count RC edges only; the core clock merely samples them.
					if (rc_rise) begin
						if (delay_done) begin
							cnt_q <= `PURSQ_ZERO32;
							st_q  <= crystal(osc_mode_i) ? ST_OST : ST_RUN;
						end else begin
							cnt_q <= cnt_q + `PURSQ_ONE32;
						end
					end
				end
				ST_OST: begin
					// The start-up count runs on the oscillator input's own edges.
					if (osc_rise) begin
						if (ost_done) begin
							cnt_q <= `PURSQ_ZERO32;
							st_q  <= ST_RUN;
						end else begin
							cnt_q <= cnt_q + `PURSQ_ONE32;
						end
					end
				end
				ST_RUN: begin
					cnt_q <= `PURSQ_ZERO32;
					if (sleep_req_q) begin
						st_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					cnt_q <= `PURSQ_ZERO32;
					if (wake) begin
						st_q <= crystal(osc_mode_i) ? ST_OST : ST_RUN;
					end
				end
				default: begin
					st_q  <= ST_POR;
					cnt_q <= `PURSQ_ZERO32;
				end
			endcase
		end
	end

	// External pin only gates release; it never restarts the timers, so a pin held
	// low past the delay releases the core as soon as it rises.
	assign core_reset_o = (st_q != ST_RUN && st_q != ST_SLEEP) | ~ext_n;

	// A request is taken on the edge where cyc and stb stand and no ack is out yet.
	wire take = cyc_i & stb_i & ~ack_o;
	// Writes need byte lane zero, which holds every writable bit.
	wire wr   = take & we_i & sel_i[`PURSQ_LANE0];
	wire rd   = take & ~we_i;

	// Ack answers one cycle after the take and drops in the cycle after.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= take;
		end
	end

	// Sleep request is a one-cycle pulse from a control write.
	always @(posedge clk_i) begin
		if (rst_i) begin
			sleep_req_q <= 1'b0;
		end else begin
			sleep_req_q <= wr & reg_hit(adr_i, `PURSQ_ADR_CTRL) & dat_i[`PURSQ_BIT_SLEEP];
		end
	end

	// Power-on flag: cleared by supply loss, set by software. The clear wins a tie,
	// so a supply event in the same cycle as the write is never hidden.
	always @(posedge clk_i) begin
		if (rst_i) begin
			por_flag_q <= 1'b0;
		end else if (!por_good) begin
			por_flag_q <= 1'b0;
		end else if (wr && reg_hit(adr_i, `PURSQ_ADR_STAT) && dat_i[`PURSQ_BIT_POR]) begin
			por_flag_q <= 1'b1;
		end
	end

	// Brown-out flag, active low: cleared by an enabled sag, set by software.
	always @(posedge clk_i) begin
		if (rst_i) begin
			bor_flag_q <= 1'b1;
		end else if (bo_low && por_good) begin
			bor_flag_q <= 1'b0;
		end else if (wr && reg_hit(adr_i, `PURSQ_ADR_STAT) && dat_i[`PURSQ_BIT_BOR]) begin
			bor_flag_q <= 1'b1;
		end
	end

	// Read data is loaded at the take and stands with ack; unmapped words read zero.
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= `PURSQ_ZERO32;
		end else if (rd && reg_hit(adr_i, `PURSQ_ADR_STAT)) begin
			dat_o <= status_word(st_q, core_reset_o, bor_flag_q, por_flag_q);
		end else begin
			dat_o <= `PURSQ_ZERO32;
		end
	end
endmodule // pursq_sequencer

// >>> sim/pursq_props.sv
// Purpose: Port properties of the power-up reset sequencer.
// Assumes: The bench drives cyc and stb together.
// Notes: Hold windows are 8 cycles, short of the real delays, so slow parts still pass.
module pursq_props (input wire clk_i, rst_i, por_good_i, brownout_low_i, cyc_i, we_i, ack_o,
	input wire power_up_timer_disable_bit_i, brownout_enable_bit_i, core_reset_o,
	input wire [1:0] osc_mode_i, input wire [3:0] adr_i, input wire [31:0] dat_o);
	timeunit 1ns / 1ns;
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_POR_HOLD: assert property (!por_good_i [*4] |-> core_reset_o) else $error("no hold");
	AST_BOR_HOLD: assert property ((brownout_enable_bit_i && brownout_low_i) [*4]
		|-> core_reset_o) else $error("no sag hold");
	AST_NO_DECLINE: assert property (!core_reset_o && por_good_i && !brownout_enable_bit_i
		&& $rose(brownout_low_i) |=> !core_reset_o [*8]) else $error("reset on sag");
	AST_DELAY_HOLD: assert property ($rose(por_good_i) && (!power_up_timer_disable_bit_i
		|| osc_mode_i != 2'h0) |=> core_reset_o [*8]) else $error("early release");
	AST_ACK_NEXT: assert property (cyc_i && !ack_o |=> ack_o) else $error("late ack");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
	AST_ACK_IDLE: assert property (!cyc_i |=> !ack_o) else $error("stray ack");
	AST_UNMAPPED: assert property (cyc_i && !we_i && adr_i == 4'h8 && !ack_o
		|=> dat_o == 32'h0000_0000) else $error("unmapped data");
endmodule // pursq_props
bind pursq_sequencer pursq_props u_props (.*);

// >>> sim/pursq_supply.sv
// Purpose: Supply detectors and oscillators facing the sequencer.
// Assumes: lvl_i 0 off, 1 sagging, 2 good; the reset pin follows good supply.
// Notes: Oscillators run free at 7 and 3 core cycles a period to keep counts short.
module pursq_supply (input wire logic [1:0] lvl_i, output logic rc_o = 1'b0,
	output logic osc_o = 1'b0, output wire logic good_o, output wire logic low_o);
	timeunit 1ns / 1ns;
	// Unrelated periods so release timing is seen at every phase.
	always #70 rc_o = ~rc_o;
	always #30 osc_o = ~osc_o;
	// The pin is held low only while the supply is off; a sag leaves it high.
	assign good_o = lvl_i != 2'h0;
	assign low_o = lvl_i != 2'h2;
endmodule // pursq_supply

// >>> sim/pursq_sequencer_bench.sv
// Purpose: Self-checking bench for the power-up reset sequencer.
// Assumes: Delay cut to 4 RC edges; RC period 7 and crystal period 3 cycles.
// Notes: Release is checked in a window, as the oscillators have no fixed phase.
module pursq_sequencer_bench;
	timeunit 1ns / 1ns;
	localparam int D = 4;
	logic clk_i = 1'b0, rst_i, req, we, pd, boe, wk;
	logic [1:0] lvl, md;
	logic [3:0] adr;
	logic [31:0] wd, rd;
	wire rc, osc, good, low, ack, crst;
	wire [31:0] dat;
	int err_count = 0, checked = 0, lo, n;
	pursq_supply sup (.lvl_i(lvl), .rc_o(rc), .osc_o(osc), .good_o(good), .low_o(low));
	pursq_sequencer #(.DELAY_RC_CYCLES(D)) dut (.clk_i(clk_i), .rst_i(rst_i), .por_good_i(good),
		.brownout_low_i(low), .ext_reset_n_i(good), .wake_i(wk), .rc_osc_i(rc), .osc_in_i(osc),
		.power_up_timer_disable_bit_i(pd), .brownout_enable_bit_i(boe), .osc_mode_i(md),
		.cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .dat_i(wd), .sel_i(4'hf),
		.dat_o(dat), .ack_o(ack), .core_reset_o(crst));
	initial forever #10 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] s, e);
		checked++;
		err_count += (s !== e);
		if (s !== e) $display("FAIL %0t %h %h", $time, s, e);
	endtask
	task automatic report_and_stop;
		if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One classic cycle; a missing ack ends the run rather than hanging it.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{req, we, adr, wd} <= {1'b1, w, a, d};
		n = 0;
		do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
		rd = dat;
		req <= 1'b0;
		err_count += (ack !== 1'b1);
		if (ack !== 1'b1) report_and_stop;
	endtask
	// Power down or sag, recover, and time the release against the model.
	task automatic pu(input int i, input logic [1:0] from);
		{md, pd, boe, lvl} <= {2'(i), i[2], from == 2'h1, from};
		repeat (20) @(posedge clk_i);
		lvl <= 2'h2;
		lo = (i[2] ? 0 : (D - 1) * 7) + (i[1:0] != 0 ? 1023 * 3 : 0);
		n = 0;
		do @(posedge clk_i); while (crst !== 1'b0 && ++n < 5000);
		chk(32'(n >= lo && n <= lo + 24), 1);
	endtask
	// Every mode with the timer on and off, flags, a sag and an unmapped place.
	initial begin
		rst_i = 1'b1;
		{req, we, adr, wd, md, pd, boe, lvl, wk} = '0;
		void'($urandom(34));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) pu(i, 2'h0);
		wb(1'b0, 4'h4, 0);
		chk(32'({rd[5:2], rd[0]}), 32'h0000_0010);
		lvl <= 2'h1;
		repeat (20) @(posedge clk_i);
		chk(32'(crst), 0);
		wb(1'b1, 4'h4, 32'h0000_0003);
		pu(0, 2'h1);
		wb(1'b0, 4'h4, 0);
		chk(32'(rd[5:0]), 32'h0000_0021);
		wb(1'b1, 4'h8, $urandom);
		wb(1'b0, 4'h8, 0);
		chk(rd, 0);
		// Sleep by a control write, then wake in crystal mode: only the start-up count runs.
		wb(1'b1, 4'h0, 32'h0000_0001);
		wb(1'b0, 4'h4, 0);
		chk(32'(rd[5:3]), 32'h0000_0005);
		{md, wk} <= {2'h2, 1'b1};
		n = 0;
		do @(posedge clk_i); while (crst !== 1'b1 && ++n < 20);
		chk(32'(crst), 1);
		n = 0;
		do @(posedge clk_i); while (crst !== 1'b0 && ++n < 5000);
		chk(32'(n >= 1023 * 3 && n <= 1023 * 3 + 24), 1);
		report_and_stop;
	end
endmodule // pursq_sequencer_bench
